// ---- logic/link_slot_consts.vh ----
// Offsets, field positions, reset values and encodings for the link status and slot capability registers
`ifndef LINK_SLOT_CONSTS_VH
`define LINK_SLOT_CONSTS_VH
`define OFF_LINK_WORD 8'hd0
`define OFF_SLOT_CAPS 8'hd4
`define SPEED_2G5 4'h1
`define SPEED_5G0 4'h2
`define SPEED_RST 4'h2
`define WIDTH_X1 6'h01
`define WIDTH_X2 6'h02
`define BIT_RETRAIN 5
`define BIT_TRAIN_ERR 26
`define BIT_TRAINING 27
`define BIT_SLOT_CLK 28
`define BIT_DL_ACTIVE 29
`define PWR_VAL_LSB 7
`define PWR_VAL_MSB 14
`define PWR_SCL_LSB 15
`define PWR_SCL_MSB 16
`define SLOT_NUM_LSB 19
`define SLOT_NUM_MSB 31
`define PWR_VAL_RST 8'h00
`define PWR_SCL_RST 2'h0
`define SLOT_NUM_RST 13'h0000
`define RO_CAPS_MASK 7'h7b
`define STRAP_FILL 2'h3
`endif

// ---- logic/link_status_slot_caps_regs.v ----
// Link status half-word and slot_feature_advert register logic for one switch port
// Function
// - Speed field 19:16 reports negotiated rate, 1 or 2, resets to 2, read-only.
// - Width field 25:20 reports trained lanes; resets x2 on port 0, x1 otherwise.
// - Bit 26 sets on training failure, clears on successful L0 entry, resets zero.
// - Bit 27 reads one while training, clears when training completes, resets one.
// - Bit 28 slot clock: resets zero, then taken once from the synchronised strap, loader may override.
// - Bit 29 reads one while data link is active, registered one cycle behind it, resets zero.
// - Slot_feature_advert word at D4h exists only on downstream ports.
// - Bit 0 read-only attention button present, resets zero.
// - Bit 1 read-only power controller present, resets zero.
// - Bits 3 and 4 read-only attention and power indicator present, reset zero.
// - Bit 5 surprise removal, bit 6 hot-plug capable, read-only, reset zero.
// - Bits 14:7 writable power limit value, resets 00h.
// - Bits 16:15 writable power limit scale, resets 00b.
// - Any write to power limit fields sends a Set_Slot_Power_Limit message, except one lost to a loader write in the same cycle.
// - Bits 31:19 read-only physical slot number, reset zero.
// - Loader may replace slot capability defaults despite software read-only view.
// - Downstream retrain control bit starts retraining; training bit reads one.
`timescale 1ns/100ps
`include "link_slot_consts.vh"

module link_status_slot_caps_regs #(
   parameter PORT_NUM = 0
) (
   input wire clk,
   input wire rstn,
   input wire slot_clock_strap,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [7:0] cfg_addr,
   input wire [31:0] cfg_wdata,
   input wire [3:0] cfg_be,
   output reg [31:0] cfg_rdata,
   output reg cfg_rvalid,
   input wire [3:0] phy_speed,
   input wire [5:0] phy_width,
   input wire train_fail,
   input wire train_done_l0,
   input wire dl_active,
   input wire ld_wr,
   input wire [7:0] ld_addr,
   input wire [31:0] ld_wdata,
   output reg retrain_req,
   output reg set_pwr_msg,
   output reg [7:0] pwr_msg_value,
   output reg [1:0] pwr_msg_scale
);

   // ****************************************
   // Decode
   // ****************************************
   localparam [0:0] is_down = (PORT_NUM != 0);
   localparam [5:0] width_rst = (PORT_NUM == 0) ? `WIDTH_X2 : `WIDTH_X1;
   localparam [6:0] ro_mask = `RO_CAPS_MASK;

   // Offset match shared by write, loader and read decoders
   function addr_is;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addr_is = (addr == offset);
      end
   endfunction

   // Keeps the speed field on one of its two legal codes
   function [3:0] speed_code;
      input [3:0] raw;
      begin
         if (raw == `SPEED_5G0) begin
            speed_code = `SPEED_5G0;
         end else begin
            speed_code = `SPEED_2G5;
         end
      end
   endfunction

   reg [3:0] speed_r;
   reg [5:0] width_r;
   reg train_err_r;
   reg training_r;
   reg [2:0] strap_sync_r;
   reg [1:0] strap_fill_r;
   reg strap_seen_r;
   reg slot_clk_r;
   reg dl_active_r;
   reg [6:0] caps_ro_r;
   reg [7:0] pwr_val_r;
   reg [1:0] pwr_scl_r;
   reg [12:0] slot_num_r;
   genvar i;

   // Write and loader strobes per register
   wire wr_link = cfg_wr && addr_is(cfg_addr, `OFF_LINK_WORD);
   wire wr_caps = cfg_wr && is_down && addr_is(cfg_addr, `OFF_SLOT_CAPS);
   wire ld_link = ld_wr && addr_is(ld_addr, `OFF_LINK_WORD);
   wire ld_caps = ld_wr && is_down && addr_is(ld_addr, `OFF_SLOT_CAPS);
   wire retrain_hit = is_down && wr_link && cfg_be[0] && cfg_wdata[`BIT_RETRAIN];
   // Loader wins, so a lost write sends no message
   wire pwr_wr = wr_caps && !ld_caps && (cfg_be[0] | cfg_be[1] | cfg_be[2]);
   // Strap is trusted only once all three stages are filled
   wire strap_settled = (strap_fill_r == `STRAP_FILL);
   wire strap_agree = (strap_sync_r[2] == strap_sync_r[1]);

   // Byte-lane merge of the power limit fields
   wire [7:0] pwr_val_nxt = {cfg_be[1] ? cfg_wdata[14:8] : pwr_val_r[7:1],
                             cfg_be[0] ? cfg_wdata[7] : pwr_val_r[0]};
   wire [1:0] pwr_scl_nxt = {cfg_be[2] ? cfg_wdata[16] : pwr_scl_r[1],
                             cfg_be[1] ? cfg_wdata[15] : pwr_scl_r[0]};

   // Read images of both words
   wire [31:0] link_word = {2'b00, dl_active_r, slot_clk_r, training_r, train_err_r,
                            width_r, speed_r, 16'h0000};
   wire [31:0] caps_word = {slot_num_r, 2'b00, pwr_scl_r, pwr_val_r,
                            caps_ro_r[6:3], 1'b0, caps_ro_r[1:0]};

   // ****************************************
   // Link speed and width
   // ****************************************
   // Captured at L0 entry
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         speed_r <= `SPEED_RST;
      end else if (train_done_l0) begin
         speed_r <= speed_code(phy_speed);
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         width_r <= width_rst;
      end else if (train_done_l0) begin
         width_r <= phy_width;
      end
   end

   // ****************************************
   // Training status
   // ****************************************
   // Failure wins over success in one cycle
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         train_err_r <= 1'b0;
      end else if (train_fail) begin
         train_err_r <= 1'b1;
      end else if (train_done_l0) begin
         train_err_r <= 1'b0;
      end
   end

   // Retrain request wins over completion in one cycle
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         training_r <= 1'b1;
      end else if (retrain_hit) begin
         training_r <= 1'b1;
      end else if (train_done_l0) begin
         training_r <= 1'b0;
      end
   end

   // ****************************************
   // Data link state
   // ****************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dl_active_r <= 1'b0;
      end else begin
         dl_active_r <= dl_active;
      end
   end

   // ****************************************
   // Slot clock strap
   // ****************************************
   // Three-stage synchroniser for the strap pin
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_sync_r <= 3'h0;
      end else begin
         strap_sync_r <= {strap_sync_r[1:0], slot_clock_strap};
      end
   end

   // Counts the edges until the synchroniser is full
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_fill_r <= 2'h0;
      end else if (!strap_settled) begin
         strap_fill_r <= strap_fill_r + 2'h1;
      end
   end

   // Strap taken once; a loader write overrides it for good
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot_clk_r <= 1'b0;
         strap_seen_r <= 1'b0;
      end else if (ld_link) begin
         slot_clk_r <= ld_wdata[`BIT_SLOT_CLK];
         strap_seen_r <= 1'b1;
      end else if (!strap_seen_r && strap_settled && strap_agree) begin
         slot_clk_r <= strap_sync_r[2];
         strap_seen_r <= 1'b1;
      end
   end

   // ****************************************
   // Slot_feature_advert
   // ****************************************
   // Presence bits change only through the loader
   generate
      for (i = 0; i < 7; i = i + 1) begin : g_caps_ro
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               caps_ro_r[i] <= 1'b0;
            end else if (ld_caps) begin
               caps_ro_r[i] <= ld_wdata[i] & ro_mask[i];
            end
         end
      end
   endgenerate

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwr_val_r <= `PWR_VAL_RST;
      end else if (ld_caps) begin
         pwr_val_r <= ld_wdata[`PWR_VAL_MSB:`PWR_VAL_LSB];
      end else if (wr_caps) begin
         pwr_val_r <= pwr_val_nxt;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwr_scl_r <= `PWR_SCL_RST;
      end else if (ld_caps) begin
         pwr_scl_r <= ld_wdata[`PWR_SCL_MSB:`PWR_SCL_LSB];
      end else if (wr_caps) begin
         pwr_scl_r <= pwr_scl_nxt;
      end
   end

   // Software cannot write the slot number
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot_num_r <= `SLOT_NUM_RST;
      end else if (ld_caps) begin
         slot_num_r <= ld_wdata[`SLOT_NUM_MSB:`SLOT_NUM_LSB];
      end
   end

   // ****************************************
   // Power limit message and retrain
   // ****************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         set_pwr_msg <= 1'b0;
      end else begin
         set_pwr_msg <= pwr_wr;
      end
   end

   // Message payload stands with the pulse and after it
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwr_msg_value <= 8'h00;
         pwr_msg_scale <= 2'h0;
      end else if (pwr_wr) begin
         pwr_msg_value <= pwr_val_nxt;
         pwr_msg_scale <= pwr_scl_nxt;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         retrain_req <= 1'b0;
      end else begin
         retrain_req <= retrain_hit;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
      end
   end

   // Read data holds until the next read
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata <= 32'h00000000;
      end else if (cfg_rd) begin
         if (addr_is(cfg_addr, `OFF_LINK_WORD)) begin
            cfg_rdata <= link_word;
         end else if (is_down && addr_is(cfg_addr, `OFF_SLOT_CAPS)) begin
            cfg_rdata <= caps_word;
         end else begin
            cfg_rdata <= 32'h00000000;
         end
      end
   end

endmodule

// ---- verification/link_partner_model.sv ----
// Link training partner that turns bench commands into training events
`timescale 1ns/100ps
module link_partner_model (
   input wire clk,
   input wire rstn,
   input wire [1:0] cmd,
   output reg train_fail,
   output reg train_done_l0,
   output wire [3:0] phy_speed,
   output wire [5:0] phy_width,
   output reg dl_active
);
assign phy_speed = 4'h1;
assign phy_width = 6'h02;
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      {train_fail, train_done_l0, dl_active} <= 3'h0;
   end else begin
      {train_fail, train_done_l0} <= {cmd == 2'h1, cmd == 2'h2};
      dl_active <= dl_active | (cmd == 2'h2);
   end
end
endmodule

// ---- verification/link_slot_sva.sv ----
// Port checks for the link status and slot capability registers
`timescale 1ns/100ps
module link_slot_sva #(parameter PORT_NUM = 1) (
   input wire clk, input wire rstn, input wire cfg_wr, input wire cfg_rd, input wire ld_wr,
   input wire [7:0] cfg_addr, input wire [31:0] cfg_wdata, input wire [3:0] cfg_be,
   input wire [31:0] cfg_rdata, input wire cfg_rvalid, input wire dl_active,
   input wire retrain_req, input wire set_pwr_msg, input wire [7:0] pwr_msg_value
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
sequence pwr_wr;
   cfg_wr && cfg_addr == 8'hd4 && cfg_be[2:0] != 3'h0 && !ld_wr && PORT_NUM != 0;
endsequence
sequence rd_d0;
   cfg_rvalid && $past(cfg_addr) == 8'hd0;
endsequence
rd_answer_a: assert property (cfg_rd |=> cfg_rvalid) else $error("read unanswered");
up_quiet_a: assert property (PORT_NUM == 0 |-> !set_pwr_msg && !retrain_req)
   else $error("upstream event");
pwr_msg_a: assert property (pwr_wr |=> set_pwr_msg)
   else $error("no power message");
msg_cause_a: assert property (set_pwr_msg |-> $past(cfg_wr))
   else $error("stray power message");
pwr_value_a: assert property (pwr_wr ##0 cfg_be == 4'hf |=> pwr_msg_value == $past(cfg_wdata[14:7]))
   else $error("bad power value");
retrain_a: assert property (cfg_wr && cfg_addr == 8'hd0 && cfg_be[0] && cfg_wdata[5]
   && !ld_wr && PORT_NUM != 0 |=> retrain_req) else $error("no retrain");
speed_code_a: assert property (rd_d0 |-> cfg_rdata[19:16] inside {4'h1, 4'h2})
   else $error("bad speed");
dl_track_a: assert property (rd_d0 |-> cfg_rdata[29] == $past(dl_active, 2))
   else $error("bad link active");
rsvd_link_a: assert property (rd_d0 |-> cfg_rdata[31:30] == 2'h0)
   else $error("reserved set");
endmodule
bind link_status_slot_caps_regs link_slot_sva #(.PORT_NUM(PORT_NUM)) u_link_slot_sva(.clk,
   .rstn, .cfg_wr, .cfg_rd, .ld_wr, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata, .cfg_rvalid,
   .dl_active, .retrain_req, .set_pwr_msg, .pwr_msg_value);

// ---- verification/link_status_slot_caps_regs_tb_top.sv ----
// Testbench for the link status and slot capability registers
`timescale 1ns/100ps
module link_status_slot_caps_regs_tb_top;
reg clk = 0, rstn = 0, slot_clock_strap = 1, cfg_wr = 0, cfg_rd = 0, ld_wr = 0;
reg [7:0] cfg_addr = 8'h00, ld_addr = 8'h00;
reg [31:0] cfg_wdata = 32'h0, ld_wdata = 32'h0, rv, up_rv;
wire [31:0] up_rdata;
wire [7:0] up_msg_value;
wire [1:0] up_msg_scale;
wire up_rvalid, up_retrain, up_msg;
reg [3:0] cfg_be = 4'h0;
reg [1:0] cmd = 2'h0;
wire [31:0] cfg_rdata;
wire [3:0] phy_speed;
wire [5:0] phy_width;
wire [7:0] pwr_msg_value;
wire [1:0] pwr_msg_scale;
wire cfg_rvalid, train_fail, train_done_l0, dl_active, retrain_req, set_pwr_msg;
integer failures = 0, checked = 0;
initial forever #2 clk = ~clk;
link_partner_model u_link_partner_model(.clk, .rstn, .cmd, .train_fail, .train_done_l0,
   .phy_speed, .phy_width, .dl_active);
link_status_slot_caps_regs #(.PORT_NUM(1)) u_link_status_slot_caps_regs(.clk, .rstn,
   .slot_clock_strap, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata,
   .cfg_rvalid, .phy_speed, .phy_width, .train_fail, .train_done_l0, .dl_active, .ld_wr,
   .ld_addr, .ld_wdata, .retrain_req, .set_pwr_msg, .pwr_msg_value, .pwr_msg_scale);
link_status_slot_caps_regs #(.PORT_NUM(0)) u_link_status_slot_caps_regs_up(.clk, .rstn,
   .slot_clock_strap, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be,
   .cfg_rdata(up_rdata), .cfg_rvalid(up_rvalid), .phy_speed, .phy_width, .train_fail,
   .train_done_l0, .dl_active, .ld_wr, .ld_addr, .ld_wdata, .retrain_req(up_retrain),
   .set_pwr_msg(up_msg), .pwr_msg_value(up_msg_value), .pwr_msg_scale(up_msg_scale));
task chk(input [8*6:1] n, input [31:0] seen, input [31:0] exp); begin
   checked = checked + 1;
   if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0s expected %h seen %h", n, exp, seen);
   end
end endtask
task wr(input l, input [7:0] a, input [31:0] d, input [3:0] b); begin
   @(posedge clk);
   if (l) {ld_wr, ld_addr, ld_wdata} <= {1'b1, a, d};
   else {cfg_wr, cfg_addr, cfg_wdata, cfg_be} <= {1'b1, a, d, b};
   @(posedge clk);
   {ld_wr, cfg_wr} <= 2'h0;
   #1;
end endtask
task rd(input [7:0] a); begin
   @(posedge clk);
   {cfg_rd, cfg_addr} <= {1'b1, a};
   @(posedge clk);
   cfg_rd <= 0;
   #1 {rv, up_rv} = {cfg_rdata, up_rdata};
end endtask
task ev(input [1:0] c); begin
   @(posedge clk);
   cmd <= c;
   @(posedge clk);
   cmd <= 0;
   repeat (3) @(posedge clk);
end endtask
task conclude; begin
   $display("checked %0d failures %0d", checked, failures);
   if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
end endtask
initial begin
   #20000;
   failures = failures + 1;
   conclude;
end
initial begin
   repeat (20) @(posedge clk);
   rstn <= 1;
   repeat (6) @(posedge clk);
   rd(8'hd0);
   chk("lnk", {16'h0, rv[31:16]}, 32'h1812);
   chk("uplnk", {16'h0, up_rv[31:16]}, 32'h1822);
   rd(8'hd4);
   chk("cap", rv, 32'h0);
   chk("upcap", up_rv, 32'h0);
   $display("reset test done");
   wr(0, 8'hd4, 32'hffffffff, 4'hf);
   chk("msg", {29'h0, set_pwr_msg, pwr_msg_scale}, 32'h7);
   chk("val", {24'h0, pwr_msg_value}, 32'hff);
   chk("upmsg", {31'h0, up_msg}, 32'h0);
   rd(8'hd4);
   chk("capwr", rv, 32'h0001ff80);
   chk("upcw", up_rv, 32'h0);
   wr(0, 8'hd0, 32'hffff0000, 4'hc);
   rd(8'hd0);
   chk("lnkro", {16'h0, rv[31:16]}, 32'h1812);
   $display("write test done");
   ev(2'h1);
   rd(8'hd0);
   chk("err", {31'h0, rv[26]}, 32'h1);
   ev(2'h2);
   rd(8'hd0);
   chk("trn", {16'h0, rv[31:16]}, 32'h3021);
   wr(0, 8'hd0, 32'h20, 4'h1);
   chk("rtr", {31'h0, retrain_req}, 32'h1);
   chk("uprtr", {31'h0, up_retrain}, 32'h0);
   rd(8'hd0);
   chk("rtrbit", {31'h0, rv[27]}, 32'h1);
   $display("training test done");
   wr(1, 8'hd4, 32'h0008007b, 4'h0);
   rd(8'hd4);
   chk("ldcap", rv, 32'h0008007b);
   chk("upld", up_rv, 32'h0);
   rd(8'h40);
   chk("unmap", rv, 32'h0);
   $display("loader test done");
   conclude;
end
endmodule
